// ---- design/decimal_adjust.sv ----
`timescale 1ns/1ps
module decimal_adjust (
	input wire logic [4:0] raw,
	input wire logic is_sub,
	input wire logic bcd,
	output logic [3:0] result,
	output logic carry
);

	always_comb begin
		result = raw[3:0];
		carry = raw[4];
		if (bcd) begin
			if (is_sub) begin
				if (raw[4]) begin
					result = raw[3:0] - alu_pkg::DEC_CORR;
				end
			end else if (raw > alu_pkg::DEC_LIMIT) begin
				result = raw[3:0] + alu_pkg::DEC_CORR;
				carry = 1'b1;
			end
		end
	end

endmodule

// ---- design/dm_addr_ctrl.sv ----
`timescale 1ns/1ps
module dm_addr_ctrl (
	input wire logic [6:0] gen_reg_pointer,
	input wire logic [3:0] bank,
	input wire logic [10:0] index_modifier,
	input wire logic index_mod_enable,
	input wire logic [6:0] row_pointer,
	input wire logic rowptr_mod_enable,
	input wire alu_pkg::instr_t instr,
	input wire logic [3:0] ind_col,
	output alu_pkg::dm_addr_t wreg_addr,
	output alu_pkg::dm_addr_t mem_addr,
	output alu_pkg::dm_addr_t ind_addr
);

	alu_pkg::dm_addr_t raw_addr;

	always_comb begin
		// working row: bank and row from the pointer, column from r
		wreg_addr.bank = gen_reg_pointer[6:3];
		wreg_addr.row = gen_reg_pointer[2:0];
		wreg_addr.col = instr.r_col;
		raw_addr.bank = bank;
		raw_addr.row = instr.m_row;
		raw_addr.col = instr.m_col;
		if (index_mod_enable &&
			instr.op != alu_pkg::OP_ROTATE_RIGHT_CARRY) begin
			mem_addr = raw_addr | index_modifier;
		end else begin
			mem_addr = raw_addr;
		end
		// indirect target follows the memory operand's bank and row
		ind_addr.bank = mem_addr.bank;
		ind_addr.row = mem_addr.row;
		ind_addr.col = ind_col;
		if (rowptr_mod_enable) begin
			ind_addr.bank = row_pointer[6:3];
			ind_addr.row = row_pointer[2:0];
		end
	end

endmodule

// ---- design/nibble_alu_with_gen_register.sv ----
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - working row is sixteen nibbles, pointer-selected row
// - r-form address: pointer bank/row, column r
// - indirect target: operand bank/row, column from row
// - working row bank independent of current bank
// - row-memory operation completes within one instruction
// - ordinary memory instructions reach row nibbles too
// - arithmetic, logic, test, compare, rotate, move on nibbles
// - two hidden temporaries hold operands
// - decimal flag set adjusts add/sub results
// - address controller applies index and pointer modification
// - compare flag set discards add/sub result
// - compare clear: zero flag set on zero result
// - compare set: zero kept on zero, else cleared
// - status word steers ALU and records carry/zero
// - carry flag set on carry or borrow
// - rotate right uses and reloads carry flag
// - pointer enable replaces indirect bank and row
// - index enable ORs index into memory address, except for rotate right
module nibble_alu_with_gen_register (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic instr_valid,
	input wire alu_pkg::instr_t instr,
	output logic instr_ready,
	output logic exec_done,
	output logic exec_skip,
	output alu_pkg::dm_addr_t dm_rd_a_addr,
	output alu_pkg::dm_addr_t dm_rd_b_addr,
	output logic dm_rd_en,
	input wire logic [3:0] dm_rd_a_data,
	input wire logic [3:0] dm_rd_b_data,
	output alu_pkg::dm_addr_t dm_wr_addr,
	output logic [3:0] dm_wr_data,
	output logic dm_wr_en
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ISSUE = 4'b0010,
		S_WAIT = 4'b0100,
		S_LATCH = 4'b1000
	} state_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'b01,
		P_EXEC = 2'b10
	} phase_t;

	state_t state_q;
	phase_t phase_q;
	alu_pkg::instr_t instr_q;
	alu_pkg::status_word_t status_q;
	logic [6:0] grp_q;
	logic [10:0] index_modifier_q;
	logic [6:0] row_pointer_q;
	logic [3:0] bank_q;
	logic rowptr_mod_enable_q;
	logic [3:0] temp_a_q;
	logic [3:0] temp_b_q;
	logic ind_phase_q;
	alu_pkg::dm_addr_t wreg_addr_q;
	alu_pkg::dm_addr_t mem_addr_q;
	alu_pkg::dm_addr_t ind_addr_q;
	logic skip_last_q;
	logic instr_ready_q;
	logic exec_done_q;
	logic exec_skip_q;
	alu_pkg::dm_addr_t rd_a_addr_q;
	alu_pkg::dm_addr_t rd_b_addr_q;
	logic rd_en_q;
	alu_pkg::dm_addr_t wr_addr_q;
	logic [3:0] wr_data_q;
	logic wr_en_q;
	logic ahb_wr_q;
	logic ahb_rd_q;
	logic [7:0] ahb_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic addr_ok;
	logic bus_wr;
	alu_pkg::dm_addr_t wreg_addr;
	alu_pkg::dm_addr_t mem_addr;
	alu_pkg::dm_addr_t ind_addr;
	logic [3:0] opnd_x;
	logic [3:0] opnd_y;
	logic carry_in;
	logic [4:0] raw;
	logic is_arith;
	logic is_sub;
	logic [3:0] adj_res;
	logic adj_carry;
	logic [3:0] res_d;
	logic wr_en_d;
	alu_pkg::dm_addr_t wr_addr_d;
	logic skip_d;
	logic carry_upd;
	logic carry_new;
	logic zero_upd;
	logic zero_new;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// ------------------------------------------------------------
	// address controller and decimal adjust
	// ------------------------------------------------------------
	dm_addr_ctrl u_addr (
		.gen_reg_pointer(grp_q),
		.bank(bank_q),
		.index_modifier(index_modifier_q),
		.index_mod_enable(status_q.index_mod_enable),
		.row_pointer(row_pointer_q),
		.rowptr_mod_enable(rowptr_mod_enable_q),
		.instr(instr_q),
		.ind_col(dm_rd_a_data),
		.wreg_addr(wreg_addr),
		.mem_addr(mem_addr),
		.ind_addr(ind_addr)
	);

	decimal_adjust u_dec (
		.raw(raw),
		.is_sub(is_sub),
		.bcd(status_q.bcd),
		.result(adj_res),
		.carry(adj_carry)
	);

	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	assign addr_ok = hsel & htrans[1] & hready;
	assign bus_wr = ahb_wr_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahb_wr_q <= 1'b0;
			ahb_rd_q <= 1'b0;
			ahb_addr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			ahb_wr_q <= addr_ok & hwrite;
			ahb_rd_q <= addr_ok & ~hwrite;
			hreadyout_q <= ~(addr_ok & ~hwrite);
			if (addr_ok) begin
				ahb_addr_q <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ahb_rd_q) begin
			hrdata_q <= 32'h0000_0000;
			if (hit(ahb_addr_q, alu_pkg::OFS_STATUS)) begin
				hrdata_q[4:0] <= status_q;
			end else if (hit(ahb_addr_q, alu_pkg::OFS_GRP)) begin
				hrdata_q[6:0] <= grp_q;
			end else if (hit(ahb_addr_q, alu_pkg::OFS_INDEX)) begin
				hrdata_q[10:0] <= index_modifier_q;
			end else if (hit(ahb_addr_q, alu_pkg::OFS_ROWPTR)) begin
				hrdata_q[6:0] <= row_pointer_q;
			end else if (hit(ahb_addr_q, alu_pkg::OFS_CTRL)) begin
				hrdata_q[3:0] <= bank_q;
				hrdata_q[alu_pkg::CTRL_ROWPTR_EN_BIT] <= rowptr_mod_enable_q;
			end else if (hit(ahb_addr_q, alu_pkg::OFS_INFO)) begin
				hrdata_q[alu_pkg::INFO_BUSY_BIT] <= ~instr_ready_q;
				hrdata_q[alu_pkg::INFO_SKIP_BIT] <= skip_last_q;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			grp_q <= alu_pkg::GRP_RST;
			index_modifier_q <= alu_pkg::INDEX_RST;
			row_pointer_q <= alu_pkg::ROWPTR_RST;
			bank_q <= alu_pkg::BANK_RST;
			rowptr_mod_enable_q <= 1'b0;
		end else if (bus_wr) begin
			if (hit(ahb_addr_q, alu_pkg::OFS_GRP)) begin
				grp_q <= hwdata[6:0];
			end
			if (hit(ahb_addr_q, alu_pkg::OFS_INDEX)) begin
				index_modifier_q <= hwdata[10:0];
			end
			if (hit(ahb_addr_q, alu_pkg::OFS_ROWPTR)) begin
				row_pointer_q <= hwdata[6:0];
			end
			if (hit(ahb_addr_q, alu_pkg::OFS_CTRL)) begin
				bank_q <= hwdata[3:0];
				rowptr_mod_enable_q <= hwdata[alu_pkg::CTRL_ROWPTR_EN_BIT];
			end
		end
	end

	// status word: hardware flag updates win over a bus write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= alu_pkg::STATUS_RST;
		end else begin
			if (bus_wr && hit(ahb_addr_q, alu_pkg::OFS_STATUS)) begin
				status_q <= hwdata[4:0];
			end
			if (phase_q == P_EXEC && carry_upd) begin
				status_q.carry_flag <= carry_new;
			end
			if (phase_q == P_EXEC && zero_upd) begin
				status_q.zero_flag <= zero_new;
			end
		end
	end

	// ------------------------------------------------------------
	// operand fetch sequence
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= S_IDLE;
			phase_q <= P_IDLE;
			instr_q <= '0;
			instr_ready_q <= 1'b1;
			ind_phase_q <= 1'b0;
			rd_en_q <= 1'b0;
			rd_a_addr_q <= '0;
			rd_b_addr_q <= '0;
			wreg_addr_q <= '0;
			mem_addr_q <= '0;
			ind_addr_q <= '0;
			temp_a_q <= 4'h0;
			temp_b_q <= 4'h0;
		end else begin
			phase_q <= P_IDLE;
			rd_en_q <= 1'b0;
			unique case (state_q)
			S_IDLE: begin
				if (instr_valid && instr_ready_q) begin
					instr_q <= instr;
					instr_ready_q <= 1'b0;
					state_q <= S_ISSUE;
				end
			end
			S_ISSUE: begin
				rd_a_addr_q <= wreg_addr;
				rd_b_addr_q <= mem_addr;
				wreg_addr_q <= wreg_addr;
				mem_addr_q <= mem_addr;
				rd_en_q <= 1'b1;
				ind_phase_q <= 1'b0;
				state_q <= S_WAIT;
			end
			S_WAIT: begin
				state_q <= S_LATCH;
			end
			S_LATCH: begin
				temp_a_q <= dm_rd_a_data;
				if (!ind_phase_q) begin
					temp_b_q <= dm_rd_b_data;
					ind_addr_q <= ind_addr;
				end
				if (!ind_phase_q &&
					instr_q.op == alu_pkg::OP_MOV_FROM_IND) begin
					rd_a_addr_q <= ind_addr;
					rd_en_q <= 1'b1;
					ind_phase_q <= 1'b1;
					state_q <= S_WAIT;
				end else begin
					phase_q <= P_EXEC;
					instr_ready_q <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// alu
	// ------------------------------------------------------------
	assign opnd_x = instr_q.use_imm ? temp_b_q : temp_a_q;
	assign opnd_y = instr_q.use_imm ? instr_q.imm : temp_b_q;
	assign is_sub = (instr_q.op == alu_pkg::OP_SUB) ||
		(instr_q.op == alu_pkg::OP_SUB_WITH_BORROW);
	assign is_arith = is_sub || (instr_q.op == alu_pkg::OP_ADD) ||
		(instr_q.op == alu_pkg::OP_ADD_WITH_CARRY);
	assign carry_in = status_q.carry_flag &
		((instr_q.op == alu_pkg::OP_ADD_WITH_CARRY) ||
		(instr_q.op == alu_pkg::OP_SUB_WITH_BORROW));
	assign raw = is_sub ?
		({1'b0, opnd_x} - {1'b0, opnd_y} - {4'h0, carry_in}) :
		({1'b0, opnd_x} + {1'b0, opnd_y} + {4'h0, carry_in});

	always_comb begin
		res_d = adj_res;
		wr_en_d = 1'b0;
		wr_addr_d = instr_q.use_imm ? mem_addr_q : wreg_addr_q;
		skip_d = 1'b0;
		carry_upd = 1'b0;
		carry_new = status_q.carry_flag;
		zero_upd = 1'b0;
		zero_new = status_q.zero_flag;
		unique case (instr_q.op)
		alu_pkg::OP_ADD, alu_pkg::OP_ADD_WITH_CARRY,
		alu_pkg::OP_SUB, alu_pkg::OP_SUB_WITH_BORROW: begin
			wr_en_d = ~status_q.compare_nostore_flag;
			carry_upd = 1'b1;
			carry_new = adj_carry;
			zero_upd = 1'b1;
			if (!status_q.compare_nostore_flag) begin
				zero_new = (adj_res == 4'h0);
			end else begin
				zero_new = (adj_res == 4'h0) & status_q.zero_flag;
			end
		end
		alu_pkg::OP_AND: begin
			res_d = opnd_x & opnd_y;
			wr_en_d = 1'b1;
		end
		alu_pkg::OP_OR: begin
			res_d = opnd_x | opnd_y;
			wr_en_d = 1'b1;
		end
		alu_pkg::OP_XOR: begin
			res_d = opnd_x ^ opnd_y;
			wr_en_d = 1'b1;
		end
		alu_pkg::OP_LOAD: begin
			res_d = temp_b_q;
			wr_en_d = 1'b1;
			wr_addr_d = wreg_addr_q;
		end
		alu_pkg::OP_STORE: begin
			res_d = temp_a_q;
			wr_en_d = 1'b1;
			wr_addr_d = mem_addr_q;
		end
		alu_pkg::OP_MOV_IMM: begin
			res_d = instr_q.imm;
			wr_en_d = 1'b1;
			wr_addr_d = mem_addr_q;
		end
		alu_pkg::OP_MOV_TO_IND: begin
			res_d = temp_b_q;
			wr_en_d = 1'b1;
			wr_addr_d = ind_addr_q;
		end
		alu_pkg::OP_MOV_FROM_IND: begin
			res_d = temp_a_q;
			wr_en_d = 1'b1;
			wr_addr_d = mem_addr_q;
		end
		alu_pkg::OP_TEST_SET: begin
			skip_d = ((temp_b_q & instr_q.imm) == instr_q.imm);
		end
		alu_pkg::OP_TEST_CLR: begin
			skip_d = ((temp_b_q & instr_q.imm) == 4'h0);
		end
		alu_pkg::OP_IS_EQ: begin
			skip_d = (temp_b_q == instr_q.imm);
		end
		alu_pkg::OP_IS_NE: begin
			skip_d = (temp_b_q != instr_q.imm);
		end
		alu_pkg::OP_IS_GE: begin
			skip_d = (temp_b_q >= instr_q.imm);
		end
		alu_pkg::OP_IS_LT: begin
			skip_d = (temp_b_q < instr_q.imm);
		end
		alu_pkg::OP_ROTATE_RIGHT_CARRY: begin
			res_d = {status_q.carry_flag, temp_a_q[3:1]};
			wr_en_d = 1'b1;
			wr_addr_d = wreg_addr_q;
			carry_upd = 1'b1;
			carry_new = temp_a_q[0];
		end
		default: begin
			wr_en_d = 1'b0;
		end
		endcase
	end

	// ------------------------------------------------------------
	// result write and completion
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_en_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= 4'h0;
			exec_done_q <= 1'b0;
			exec_skip_q <= 1'b0;
			skip_last_q <= 1'b0;
		end else begin
			wr_en_q <= 1'b0;
			exec_done_q <= 1'b0;
			exec_skip_q <= 1'b0;
			if (phase_q == P_EXEC) begin
				wr_en_q <= wr_en_d;
				wr_addr_q <= wr_addr_d;
				wr_data_q <= res_d;
				exec_done_q <= 1'b1;
				exec_skip_q <= skip_d;
				skip_last_q <= skip_d;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign instr_ready = instr_ready_q;
	assign exec_done = exec_done_q;
	assign exec_skip = exec_skip_q;
	assign dm_rd_a_addr = rd_a_addr_q;
	assign dm_rd_b_addr = rd_b_addr_q;
	assign dm_rd_en = rd_en_q;
	assign dm_wr_addr = wr_addr_q;
	assign dm_wr_data = wr_data_q;
	assign dm_wr_en = wr_en_q;

endmodule

// ---- include/alu_pkg.sv ----
package alu_pkg;

	// ------------------------------------------------------------
	// widths and counts
	// ------------------------------------------------------------
	localparam int unsigned NIB_W = 4;
	localparam int unsigned ROW_NIBBLES = 16;
	localparam int unsigned GRP_W = 7;
	localparam int unsigned IDX_W = 11;
	localparam int unsigned RPTR_W = 7;
	localparam int unsigned ST_W = 5;
	localparam int unsigned AOFS_W = 8;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_GRP = 8'h04;
	localparam logic [7:0] OFS_INDEX = 8'h08;
	localparam logic [7:0] OFS_ROWPTR = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_INFO = 8'h14;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_ROWPTR_EN_BIT = 4;
	localparam int unsigned INFO_BUSY_BIT = 0;
	localparam int unsigned INFO_SKIP_BIT = 1;
	localparam logic [4:0] STATUS_RST = 5'h00;
	localparam logic [6:0] GRP_RST = 7'h00;
	localparam logic [10:0] INDEX_RST = 11'h000;
	localparam logic [6:0] ROWPTR_RST = 7'h00;
	localparam logic [3:0] BANK_RST = 4'h0;

	// ------------------------------------------------------------
	// decimal adjustment constants
	// ------------------------------------------------------------
	localparam logic [4:0] DEC_LIMIT = 5'h09;
	localparam logic [3:0] DEC_CORR = 4'h6;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_ADD_WITH_CARRY = 5'h01,
		OP_SUB = 5'h02,
		OP_SUB_WITH_BORROW = 5'h03,
		OP_AND = 5'h04,
		OP_OR = 5'h05,
		OP_XOR = 5'h06,
		OP_LOAD = 5'h07,
		OP_STORE = 5'h08,
		OP_MOV_IMM = 5'h09,
		OP_MOV_TO_IND = 5'h0a,
		OP_MOV_FROM_IND = 5'h0b,
		OP_TEST_SET = 5'h0c,
		OP_TEST_CLR = 5'h0d,
		OP_IS_EQ = 5'h0e,
		OP_IS_NE = 5'h0f,
		OP_IS_GE = 5'h10,
		OP_IS_LT = 5'h11,
		OP_ROTATE_RIGHT_CARRY = 5'h12
	} op_t;

	typedef struct packed {
		op_t op;
		logic use_imm;
		logic [3:0] r_col;
		logic [2:0] m_row;
		logic [3:0] m_col;
		logic [3:0] imm;
	} instr_t;

	typedef struct packed {
		logic [3:0] bank;
		logic [2:0] row;
		logic [3:0] col;
	} dm_addr_t;

	typedef struct packed {
		logic bcd;
		logic compare_nostore_flag;
		logic carry_flag;
		logic zero_flag;
		logic index_mod_enable;
	} status_word_t;

endpackage

// ---- tb/alu_monitor.sv ----
`timescale 1ns/1ps
module alu_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic instr_valid,
	input wire alu_pkg::instr_t instr,
	input wire logic instr_ready,
	input wire logic exec_done,
	input wire logic exec_skip,
	input wire logic dm_rd_en,
	input wire logic dm_wr_en
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	wire logic acc = instr_valid && instr_ready;
	wire logic ind = instr.op == alu_pkg::OP_MOV_FROM_IND;
	wire logic tk = hsel && htrans[1] && hready;

	a_done_latency: assert property (
		acc && !ind |-> ##2 !exec_done [*3] ##1 exec_done)
		else $error("done not five cycles after accept");
	a_ind_latency: assert property (
		acc && ind |-> ##2 !exec_done [*5] ##1 exec_done)
		else $error("indirect done not seven cycles after accept");
	a_busy_window: assert property (
		acc && !ind |=> !instr_ready [*3] ##1 instr_ready)
		else $error("ready window wrong");
	a_read_pulse: assert property (
		acc |-> ##2 dm_rd_en ##1 !dm_rd_en)
		else $error("memory read strobe misplaced");
	a_write_done: assert property (dm_wr_en |-> exec_done)
		else $error("write strobe without done");
	a_skip_done: assert property (exec_skip |-> exec_done)
		else $error("skip without done");
	a_done_pulse: assert property (exec_done |=> !exec_done)
		else $error("done longer than one cycle");
	a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("bus read wait state wrong");
	a_write_nowait: assert property (tk && hwrite |=> hreadyout && !hresp)
		else $error("bus write stalled or errored");
endmodule

bind nibble_alu_with_gen_register alu_monitor mon_u (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
	.exec_done(exec_done), .exec_skip(exec_skip), .dm_rd_en(dm_rd_en),
	.dm_wr_en(dm_wr_en));

// ---- tb/data_mem_model.sv ----
`timescale 1ns/1ps
module data_mem_model (
	input wire logic hclk,
	input wire alu_pkg::dm_addr_t rd_a_addr,
	input wire alu_pkg::dm_addr_t rd_b_addr,
	input wire logic rd_en,
	output logic [3:0] rd_a_data,
	output logic [3:0] rd_b_data,
	input wire alu_pkg::dm_addr_t wr_addr,
	input wire logic [3:0] wr_data,
	input wire logic wr_en
);
	logic [3:0] mem [0:2047];

	initial begin
		rd_a_data = 4'h5;
		rd_b_data = 4'ha;
	end

	// ------------------------------------------------------------
	// registered read, scrambled outside its one valid cycle
	// ------------------------------------------------------------
	always @(posedge hclk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		if (rd_en) begin
			rd_a_data <= mem[rd_a_addr];
			rd_b_data <= mem[rd_b_addr];
		end else begin
			rd_a_data <= ~rd_a_data;
			rd_b_data <= ~rd_b_data;
		end
	end
endmodule

// ---- tb/nibble_alu_with_gen_register_tb.sv ----
`timescale 1ns/1ps
module nibble_alu_with_gen_register_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, instr_valid = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	wire logic hready;
	logic hreadyout, hresp, instr_ready, exec_done, exec_skip;
	logic dm_rd_en, dm_wr_en, sk, esk, cout, z, wen, cin, ptr_en;
	alu_pkg::instr_t instr = '0, in;
	alu_pkg::dm_addr_t ra, rb, wad, wa, ma, ia, da;
	logic [3:0] rda, rdb, wdat, x, y, res, r, m, bank;
	logic [4:0] st, raw;
	logic [5:0] c6;
	logic [6:0] grp, rowp;
	logic [10:0] idx;
	int failures = 0, checked = 0, seed = 56, n, k, i;
	wire logic [2:0] flags = {exec_done, instr_ready, hreadyout};

	assign hready = hreadyout;
	always #4 hclk = ~hclk;

	nibble_alu_with_gen_register dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .exec_done(exec_done),
		.exec_skip(exec_skip), .dm_rd_a_addr(ra), .dm_rd_b_addr(rb),
		.dm_rd_en(dm_rd_en), .dm_rd_a_data(rda), .dm_rd_b_data(rdb),
		.dm_wr_addr(wad), .dm_wr_data(wdat), .dm_wr_en(dm_wr_en));
	data_mem_model mem_u (.hclk(hclk), .rd_a_addr(ra), .rd_b_addr(rb),
		.rd_en(dm_rd_en), .rd_a_data(rda), .rd_b_data(rdb),
		.wr_addr(wad), .wr_data(wdat), .wr_en(dm_wr_en));

	// ------------------------------------------------------------
	// bus, instruction and checking tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic await(input int w);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (flags[w] !== 1'b1 && n < 200);
		if (flags[w] !== 1'b1) begin
			failures++;
			conclude();
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		await(0);
		htrans <= 2'b00;
		hsel <= 0;
		hwdata <= d;
		await(0);
		rd = hrdata;
	endtask

	task automatic exec(input alu_pkg::instr_t ins);
		@(posedge hclk);
		instr_valid <= 1;
		instr <= ins;
		await(1);
		instr_valid <= 0;
		await(2);
		sk = exec_skip;
	endtask

	// decimal-safe operand when the decimal flag is set
	function automatic logic [3:0] nib(input logic b);
		nib = b ? 4'($unsigned($random(seed)) % 10) : 4'($random(seed));
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		for (i = 0; i <= 32; i += 4) begin
			ahb(0, i[7:0], '0);
			check(rd, '0);
		end
		ahb(1, alu_pkg::OFS_GRP, '1);
		ahb(0, alu_pkg::OFS_GRP, '0);
		check(rd, 32'h0000_007f);
		for (i = 0; i < 300; i++) begin
			st = 5'($random(seed));
			{grp, rowp, bank, ptr_en} = 19'($random(seed));
			idx = 11'($random(seed));
			in = 21'($random(seed));
			k = $unsigned($random(seed)) % 19;
			in.op = alu_pkg::op_t'(k[4:0]);
			if (k > 6)
				in.use_imm = k == 9 || (k > 11 && k < 18);
			if (st[4])
				in.imm = 4'(in.imm % 10);
			ahb(1, alu_pkg::OFS_STATUS, {27'h0, st});
			ahb(1, alu_pkg::OFS_GRP, {25'h0, grp});
			ahb(1, alu_pkg::OFS_INDEX, {21'h0, idx});
			ahb(1, alu_pkg::OFS_ROWPTR, {25'h0, rowp});
			ahb(1, alu_pkg::OFS_CTRL, {27'h0, ptr_en, bank});
			wa = {grp, in.r_col};
			ma = {bank, in.m_row, in.m_col};
			if (st[0] && k != 18)
				ma = ma | idx;
			mem_u.mem[wa] = nib(st[4]);
			mem_u.mem[ma] = nib(st[4]);
			ia = {ma[10:4], mem_u.mem[wa]};
			if (ptr_en)
				ia[10:4] = rowp;
			if (ia != wa && ia != ma)
				mem_u.mem[ia] = nib(st[4]);
			r = mem_u.mem[wa];
			m = mem_u.mem[ma];
			{x, y, da} = in.use_imm ? {m, in.imm, ma} : {r, m, wa};
			{cout, z, wen, esk} = {st[2], st[1], 2'b10};
			c6 = {m < in.imm, m >= in.imm, m != in.imm, m == in.imm,
				(m & in.imm) == 4'h0, (m & in.imm) == in.imm};
			case (k)
			0, 1, 2, 3: begin
				cin = k[0] & st[2];
				raw = k[1] ? x - y - cin : x + y + cin;
				{cout, res} = raw;
				if (st[4] && !k[1] && raw > 5'h09) begin
					res = 4'(raw + 5'h06);
					cout = 1'b1;
				end
				if (st[4] && k[1] && cout)
					res = res - 4'h6;
				z = res == 4'h0 && (z || !st[3]);
				wen = !st[3];
			end
			4: res = x & y;
			5: res = x | y;
			6: res = x ^ y;
			7: {res, da} = {m, wa};
			8: {res, da} = {r, ma};
			9: {res, da} = {in.imm, ma};
			10: {res, da} = {m, ia};
			11: {res, da} = {mem_u.mem[ia], ma};
			18: {res, cout, da} = {st[2], r, wa};
			default: begin
				wen = 0;
				esk = c6[k - 12];
			end
			endcase
			if (!wen)
				res = mem_u.mem[da];
			exec(in);
			ahb(0, alu_pkg::OFS_STATUS, '0);
			check(rd, {27'h0, st[4:3], cout, z, st[0]});
			check(mem_u.mem[da], res);
			check(sk, esk);
			ahb(0, alu_pkg::OFS_INFO, '0);
			check(rd, {30'h0, esk, 1'b0});
		end
		conclude();
	end
endmodule
